// *** src/dac_regs_pkg.sv ***
// Package with register map, field positions and carrier types
package dac_regs_pkg;
  localparam logic [7:0] code_low_addr = 8'hfb;
  localparam logic [7:0] code_high_addr = 8'hfc;
  localparam logic [7:0] control_addr = 8'hfd;
  localparam logic [7:0] code_low_reset = 8'h00;
  localparam logic [7:0] code_high_reset = 8'h00;
  localparam logic [7:0] control_reset = 8'h00;
  localparam int pin_select_pos = 4;
  localparam int byte_mode_pos = 3;
  localparam int range_select_pos = 2;
  localparam int clear_n_pos = 1;
  localparam int power_enable_pos = 0;
  localparam logic [7:0] control_used_mask = 8'h1f;
  localparam logic [11:0] code_reset = 12'h000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_type;

  typedef struct packed {
    logic output_pin_select;
    logic output_range_select;
    logic converter_power_enable;
    logic [11:0] code;
  } converter_drive_type;
endpackage : dac_regs_pkg

// *** src/dac_code_former.sv ***
// Forms the converter input code from the two data bytes
`timescale 1ns/1ps
module dac_code_former
  import dac_regs_pkg::*;
(
  input wire logic byte_mode_select,
  input wire logic [7:0] code_low_byte,
  input wire logic [7:0] code_high_byte,
  output logic [11:0] code
);
  wire logic [11:0] byte_code;
  wire logic [11:0] word_code;
  assign byte_code = {code_low_byte, 4'h0};
  assign word_code = {code_high_byte[3:0], code_low_byte};
  // high byte ignored in byte mode
  assign code = byte_mode_select ? byte_code : word_code;
endmodule : dac_code_former

// *** src/dac_control_and_data_regs.sv ***
// Converter control and data registers on the special-function bus
`timescale 1ns/1ps
module dac_control_and_data_regs
  import dac_regs_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  input wire sfr_req_type sfr_req,
  output logic [7:0] sfr_rdata,
  output converter_drive_type converter_drive
);
  logic [7:0] code_low_byte_reg;
  logic [7:0] code_high_byte_reg;
  logic [7:0] converter_control_reg;
  logic [7:0] sfr_rdata_reg;
  converter_drive_type converter_drive_reg;

  wire logic hit_low;
  wire logic hit_high;
  wire logic hit_ctrl;
  wire logic wr_low;
  wire logic wr_high;
  wire logic wr_ctrl;
  wire logic clear_active;
  wire logic [7:0] code_low_byte_next;
  wire logic [7:0] code_high_byte_next;
  wire logic [7:0] converter_control_next;
  wire logic [7:0] sfr_rdata_next;
  wire logic [11:0] formed_code;
  wire logic update_code;
  converter_drive_type converter_drive_next;

  // Address match shared by every register decode
  function automatic logic addr_match(input logic [7:0] addr,
      input logic [7:0] target);
    return addr == target;
  endfunction : addr_match

  assign hit_low = addr_match(sfr_req.addr, code_low_addr);
  assign hit_high = addr_match(sfr_req.addr, code_high_addr);
  assign hit_ctrl = addr_match(sfr_req.addr, control_addr);
  assign wr_low = sfr_req.wr && hit_low;
  assign wr_high = sfr_req.wr && hit_high;
  assign wr_ctrl = sfr_req.wr && hit_ctrl;

  assign converter_control_next = wr_ctrl ?
      (sfr_req.wdata & control_used_mask) : converter_control_reg;

  chk_reserved_zero: assert property (
      @(posedge clock) disable iff (!nrst)
      converter_control_reg[7:5] == 3'h0)
    else $error("reserved control bits set");
  chk_ctrl_write: assert property (
      @(posedge clock) disable iff (!nrst)
      (clk_en && wr_ctrl) |=> converter_control_reg ==
      ($past(sfr_req.wdata) & control_used_mask))
    else $error("control write not stored");
  chk_ctrl_hold: assert property (
      @(posedge clock) disable iff (!nrst)
      (clk_en && !wr_ctrl) |=> $stable(converter_control_reg))
    else $error("control changed without a write");

  // clear bit low holds data at zero
  assign clear_active = !converter_control_reg[clear_n_pos];
  assign code_low_byte_next = clear_active ? 8'h00 :
      (wr_low ? sfr_req.wdata : code_low_byte_reg);
  assign code_high_byte_next = clear_active ? 8'h00 :
      (wr_high ? sfr_req.wdata : code_high_byte_reg);

  chk_clear_zero: assert property (
      @(posedge clock) disable iff (!nrst)
      (clk_en && clear_active) |=>
      (code_low_byte_reg == 8'h00 && code_high_byte_reg == 8'h00 &&
      converter_drive.code == 12'h000))
    else $error("clear did not zero data");
  chk_low_write: assert property (
      @(posedge clock) disable iff (!nrst)
      (clk_en && wr_low && !clear_active) |=>
      code_low_byte_reg == $past(sfr_req.wdata))
    else $error("low byte write not stored");
  chk_high_write: assert property (
      @(posedge clock) disable iff (!nrst)
      (clk_en && wr_high && !clear_active) |=>
      code_high_byte_reg == $past(sfr_req.wdata))
    else $error("high byte write not stored");

  assign sfr_rdata_next = !sfr_req.rd ? sfr_rdata_reg :
      hit_low ? code_low_byte_reg :
      hit_high ? code_high_byte_reg :
      hit_ctrl ? converter_control_reg : 8'h00;

  chk_read_low: assert property (
      @(posedge clock) disable iff (!nrst)
      (clk_en && sfr_req.rd && hit_low) |=>
      sfr_rdata == $past(code_low_byte_reg))
    else $error("low byte read wrong");
  chk_read_high: assert property (
      @(posedge clock) disable iff (!nrst)
      (clk_en && sfr_req.rd && hit_high) |=>
      sfr_rdata == $past(code_high_byte_reg))
    else $error("high byte read wrong");
  chk_read_ctrl: assert property (
      @(posedge clock) disable iff (!nrst)
      (clk_en && sfr_req.rd && hit_ctrl) |=>
      sfr_rdata == $past(converter_control_reg))
    else $error("control read wrong");
  chk_read_unmapped: assert property (
      @(posedge clock) disable iff (!nrst)
      (clk_en && sfr_req.rd && !hit_low && !hit_high && !hit_ctrl) |=>
      sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (
      @(posedge clock) disable iff (!nrst)
      (clk_en && !sfr_req.rd) |=> $stable(sfr_rdata))
    else $error("read data changed without a read");

  dac_code_former code_former (
    .byte_mode_select(converter_control_reg[byte_mode_pos]),
    .code_low_byte(code_low_byte_next),
    .code_high_byte(code_high_byte_next),
    .code(formed_code)
  );

  // low byte write or active clear applies the code
  assign update_code = wr_low || clear_active;

  chk_byte_code: assert property (
      @(posedge clock) disable iff (!nrst)
      (clk_en && wr_low && converter_control_reg[byte_mode_pos] &&
      !clear_active) |=> converter_drive.code ==
      {$past(sfr_req.wdata), 4'h0})
    else $error("byte mode code wrong");
  chk_word_code: assert property (
      @(posedge clock) disable iff (!nrst)
      (clk_en && wr_low && !converter_control_reg[byte_mode_pos] &&
      !clear_active) |=> converter_drive.code ==
      {code_high_byte_reg[3:0], code_low_byte_reg})
    else $error("word mode code wrong");
  chk_code_update: assert property (
      @(posedge clock) disable iff (!nrst)
      (clk_en && wr_low && !clear_active &&
      converter_control_reg[byte_mode_pos]) |=>
      converter_drive.code[3:0] == 4'h0)
    else $error("byte mode low bits not zero");
  chk_write_applies: assert property (
      @(posedge clock) disable iff (!nrst)
      (clk_en && wr_low && !clear_active) |=>
      converter_drive.code == ($past(converter_control_reg[byte_mode_pos]) ?
      {$past(sfr_req.wdata), 4'h0} :
      {$past(code_high_byte_reg[3:0]), $past(sfr_req.wdata)}))
    else $error("low byte write not applied");
  chk_high_no_update: assert property (
      @(posedge clock) disable iff (!nrst)
      (clk_en && !wr_low && !clear_active) |=>
      $stable(converter_drive.code))
    else $error("code changed without low byte write");

  always_comb begin
    converter_drive_next = converter_drive_reg;
    converter_drive_next.output_pin_select =
        converter_control_reg[pin_select_pos];
    converter_drive_next.output_range_select =
        converter_control_reg[range_select_pos];
    converter_drive_next.converter_power_enable =
        converter_control_reg[power_enable_pos];
    if (update_code) begin
      converter_drive_next.code = formed_code;
    end
  end

  chk_pin_follows: assert property (
      @(posedge clock) disable iff (!nrst)
      clk_en |=> converter_drive.output_pin_select ==
      $past(converter_control_reg[pin_select_pos]))
    else $error("pin select not following control");
  chk_range_follows: assert property (
      @(posedge clock) disable iff (!nrst)
      clk_en |=> converter_drive.output_range_select ==
      $past(converter_control_reg[range_select_pos]))
    else $error("range select not following control");
  chk_power_follows: assert property (
      @(posedge clock) disable iff (!nrst)
      clk_en |=> converter_drive.converter_power_enable ==
      $past(converter_control_reg[power_enable_pos]))
    else $error("power enable not following control");

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      code_low_byte_reg <= code_low_reset;
      code_high_byte_reg <= code_high_reset;
      converter_control_reg <= control_reset;
      sfr_rdata_reg <= 8'h00;
      converter_drive_reg <= '0;
    end else if (clk_en) begin
      code_low_byte_reg <= code_low_byte_next;
      code_high_byte_reg <= code_high_byte_next;
      converter_control_reg <= converter_control_next;
      sfr_rdata_reg <= sfr_rdata_next;
      converter_drive_reg <= converter_drive_next;
    end
  end

  chk_enable_freeze: assert property (
      @(posedge clock) disable iff (!nrst)
      !clk_en |=> $stable(converter_drive) && $stable(sfr_rdata))
    else $error("outputs changed while clock enable low");

  assign sfr_rdata = sfr_rdata_reg;
  assign converter_drive = converter_drive_reg;
endmodule : dac_control_and_data_regs

// *** tb/dac_control_and_data_regs_bench.sv ***
// Self-checking bench for the converter control and data registers
`timescale 1ns/1ps
module dac_control_and_data_regs_bench;
  import dac_regs_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  sfr_req_type sfr_req = '0;
  logic [7:0] sfr_rdata;
  converter_drive_type converter_drive;
  logic [15:0] lfsr_reg = 16'h10b0;
  logic [7:0] rd_q[$];
  logic rd_taken = 1'b0;
  logic [7:0] hi;
  logic [7:0] lo;
  logic [11:0] expc;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  dac_control_and_data_regs dut_u (.clock(clock), .nrst(nrst),
    .clk_en(clk_en), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .converter_drive(converter_drive));
  initial begin
    forever #2.5 clock = ~clock;
  end
  function automatic logic [15:0] lfsr_step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_step
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  // One bus cycle; for a read, d is the expected data
  task automatic access(input logic w, input logic [7:0] a,
      input logic [7:0] d);
    @(posedge clock);
    sfr_req <= '{w, ~w, a, d};
    if (!w && clk_en) rd_q.push_back(d);
    @(posedge clock);
    sfr_req <= '0;
    #1;
  endtask : access
  // Read data appears the cycle after the read is taken
  always @(posedge clock) begin
    cycles++;
    if (rd_taken) check("read data", sfr_rdata, rd_q.pop_front());
    rd_taken <= sfr_req.rd & clk_en;
    if (cycles == 4000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    access(1'b0, code_low_addr, 8'h00);
    access(1'b0, code_high_addr, 8'h00);
    access(1'b0, control_addr, 8'h00);
    check("drive at reset", converter_drive, '0);
    access(1'b1, code_low_addr, 8'h5a);
    access(1'b0, code_low_addr, 8'h00);
    for (int c = 0; c < 32; c++) begin
      access(1'b1, control_addr, {3'b111, 5'(c)});
      access(1'b0, control_addr, {3'b000, 5'(c)});
      check("pin", converter_drive.output_pin_select, c[4]);
      check("range", converter_drive.output_range_select, c[2]);
      check("power", converter_drive.converter_power_enable, c[0]);
    end
    access(1'b1, control_addr, 8'h0b);
    for (int i = 0; i < 8; i++) begin
      lfsr_reg = lfsr_step(lfsr_reg);
      hi = lfsr_reg[15:8];
      lo = lfsr_reg[7:0];
      access(1'b1, code_high_addr, hi);
      access(1'b1, code_low_addr, lo);
      expc = (i < 4) ? {lo, 4'h0} : {hi[3:0], lo};
      check("code", converter_drive.code, expc);
      access(1'b0, code_high_addr, hi);
      if (i == 3) access(1'b1, control_addr, 8'h03);
      lfsr_reg = lfsr_step(lfsr_reg);
      access(1'b1, code_high_addr, lfsr_reg[7:0]);
      check("code held", converter_drive.code, expc);
    end
    @(posedge clock);
    clk_en <= 1'b0;
    access(1'b1, code_low_addr, ~lo);
    @(posedge clock);
    clk_en <= 1'b1;
    check("frozen code", converter_drive.code, expc);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    check("drive after reset", converter_drive, '0);
    access(1'b0, control_addr, 8'h00);
    access(1'b0, code_high_addr, 8'h00);
    access(1'b1, control_addr, 8'h03);
    access(1'b1, code_low_addr, 8'ha5);
    check("code after reset", converter_drive.code, 12'h0a5);
    access(1'b1, 8'hfe, 8'hff);
    access(1'b0, 8'hfe, 8'h00);
    access(1'b1, control_addr, 8'h01);
    access(1'b0, code_low_addr, 8'h00);
    access(1'b0, code_high_addr, 8'h00);
    check("cleared code", converter_drive.code, 12'h000);
    repeat (2) @(posedge clock);
    test_done();
  end
endmodule : dac_control_and_data_regs_bench
